//--- logic/ach_alarm_command_handler.v
`timescale 1ns/1ps
`include "ach_defs.vh"
module ach_alarm_command_handler (
	// Clock and reset
	input wire core_clk,
	input wire resetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Fault sources, asynchronous pins
	input wire [7:0] faultMain,
	input wire [7:0] faultSub,
	input wire [15:0] cautionCode,
	input wire [2:0] faultAttr,
	input wire supplyLow,
	// Actions toward the servo core
	output reg historyErase,
	output reg scaleErrClear,
	// Interrupt
	output wire irq
);
	reg [11:0] typeCode;
	reg [15:0] cmdIndex;
	reg [31:0] auxWord;
	reg [31:0] cfg;
	reg [31:0] rsp;
	reg [15:0] errCode;
	reg [1:0] irqStatus;
	reg [1:0] irqMask;
	reg busy;
	reg [7:0] mainS1, mainS2, subS1, subS2;
	reg [15:0] cauS1, cauS2;
	reg [2:0] attrS1, attrS2;
	reg lowS1, lowS2;
	reg [15:0] next_err;
	reg [31:0] next_rsp;
	wire wrEn = psel & penable & pwrite;
	wire goCmd = wrEn & (paddr == `ACH_REG_CMD);
	wire [15:0] cmdKey = cfg[`ACH_CFG_KEY_LSB +: 16];
	wire legacy = cfg[`ACH_CFG_EXT_LSB + `ACH_LEGACY_BIT];
	wire [7:0] subOut = legacy ? 8'h00 : subS2;
	wire [31:0] codes = {cauS2, subOut, mainS2};

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(irqStatus & irqMask);

	// Pins pass two flops first
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mainS1 <= 8'h00; mainS2 <= 8'h00;
			subS1 <= 8'h00; subS2 <= 8'h00;
			cauS1 <= 16'h0000; cauS2 <= 16'h0000;
			attrS1 <= 3'h0; attrS2 <= 3'h0;
			lowS1 <= 1'b0; lowS2 <= 1'b0;
		end else begin
			mainS1 <= faultMain; mainS2 <= mainS1;
			subS1 <= faultSub; subS2 <= subS1;
			cauS1 <= cautionCode; cauS2 <= cauS1;
			attrS1 <= faultAttr; attrS2 <= attrS1;
			lowS1 <= supplyLow; lowS2 <= lowS1;
		end
	end

	// Decode the command in priority order
	always @* begin
		next_err = `ACH_ERR_NONE;
		next_rsp = 32'h0000_0000;
		case (typeCode)
		`ACH_TYPE_HCLR, `ACH_TYPE_SCLR: begin
			if (cmdIndex != 16'h0000)
				next_err = `ACH_ERR_ARG;
			else if (cmdKey == 16'h0000 && auxWord != 32'h0000_0000)
				next_err = `ACH_ERR_ARG;
			else if (typeCode == `ACH_TYPE_HCLR && lowS2)
				next_err = `ACH_ERR_STORE;
			else if (typeCode == `ACH_TYPE_SCLR &&
			    (!cfg[`ACH_CFG_FULL] || cfg[`ACH_CFG_QUAD]))
				next_err = `ACH_ERR_MODE;
			else
				next_rsp = codes;
		end
		`ACH_TYPE_ATTR: begin
			next_rsp = {24'h00_0000, attrS2[2], attrS2[1],
			    attrS2[0], 5'h00};
		end
		default: next_err = `ACH_ERR_TYPE;
		endcase
	end

	// Registers and command execution
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			typeCode <= 12'h000;
			cmdIndex <= 16'h0000;
			auxWord <= 32'h0000_0000;
			cfg <= 32'h0000_0000;
			rsp <= 32'h0000_0000;
			errCode <= 16'h0000;
			irqStatus <= 2'h0;
			irqMask <= 2'h0;
			busy <= 1'b0;
			historyErase <= 1'b0;
			scaleErrClear <= 1'b0;
		end else begin
			historyErase <= 1'b0;
			scaleErrClear <= 1'b0;
			busy <= goCmd;
			if (goCmd)
				typeCode <= pwdata[11:0];
			if (wrEn && paddr == `ACH_REG_IDX)
				cmdIndex <= pwdata[15:0];
			if (wrEn && paddr == `ACH_REG_AUX)
				auxWord <= pwdata;
			if (wrEn && paddr == `ACH_REG_CFG)
				cfg <= pwdata;
			if (wrEn && paddr == `ACH_REG_IMSK)
				irqMask <= pwdata[1:0];
			// Set beats clear so no event is lost
			irqStatus <= (wrEn && paddr == `ACH_REG_IST) ?
			    irqStatus & ~pwdata[1:0] : irqStatus;
			if (busy) begin
				rsp <= next_rsp;
				errCode <= next_err;
				irqStatus[`ACH_IRQ_DONE] <= 1'b1;
				if (next_err != `ACH_ERR_NONE)
					irqStatus[`ACH_IRQ_ERR] <= 1'b1;
				historyErase <= (next_err == `ACH_ERR_NONE) &&
				    (typeCode == `ACH_TYPE_HCLR);
				scaleErrClear <= (next_err == `ACH_ERR_NONE) &&
				    (typeCode == `ACH_TYPE_SCLR);
			end
		end
	end

	// Read mux, unmapped reads zero
	always @* begin
		case (paddr)
		`ACH_REG_CMD: prdata = {20'h0_0000, typeCode};
		`ACH_REG_IDX: prdata = {16'h0000, cmdIndex};
		`ACH_REG_AUX: prdata = auxWord;
		`ACH_REG_CFG: prdata = cfg;
		`ACH_REG_RSP: prdata = rsp;
		`ACH_REG_ERR: prdata = {16'h0000, errCode};
		`ACH_REG_STS: prdata = {31'h0000_0000, busy};
		`ACH_REG_IST: prdata = {30'h0000_0000, irqStatus};
		`ACH_REG_IMSK: prdata = {30'h0000_0000, irqMask};
		`ACH_REG_FLT: prdata = codes;
		default: prdata = 32'h0000_0000;
		endcase
	end
endmodule // ach_alarm_command_handler

//--- logic/ach_defs.vh
// Summary of operation
// - History clear, index zero: erase, report codes
// - Nonzero index on either clear: error 0032h
// - Key zero, auxiliary word nonzero: error 0032h
// - History clear with storage unusable from undervoltage: error 0061h
// - Scale clear in full-closed: clear scale, report codes
// - Not full-closed or quadrature scale: error 0043h
// - Unknown type code: error 0031h
// - Fault main in byte 12, sub byte 13
// - Legacy mode bit 1: sub byte zero
// - Attribute byte 12: skip, no-clear, halt flags
// - Attribute read returns bytes 12 to 15
`ifndef ACH_DEFS_VH
`define ACH_DEFS_VH
`define ACH_TYPE_ATTR 12'h002
`define ACH_TYPE_HCLR 12'h011
`define ACH_TYPE_SCLR 12'h021
`define ACH_ERR_NONE 16'h0000
`define ACH_ERR_TYPE 16'h0031
`define ACH_ERR_ARG 16'h0032
`define ACH_ERR_MODE 16'h0043
`define ACH_ERR_STORE 16'h0061
`define ACH_LEGACY_BIT 1
`define ACH_ATTR_SKIP 7
`define ACH_ATTR_NOCLR 6
`define ACH_ATTR_HALT 5
// APB register byte addresses
`define ACH_REG_CMD 12'h000
`define ACH_REG_IDX 12'h004
`define ACH_REG_AUX 12'h008
`define ACH_REG_CFG 12'h00C
`define ACH_REG_RSP 12'h010
`define ACH_REG_ERR 12'h014
`define ACH_REG_STS 12'h018
`define ACH_REG_IST 12'h01C
`define ACH_REG_IMSK 12'h020
`define ACH_REG_FLT 12'h024
// Config field positions
`define ACH_CFG_KEY_LSB 0
`define ACH_CFG_EXT_LSB 16
`define ACH_CFG_FULL 24
`define ACH_CFG_QUAD 25
// Interrupt status bits
`define ACH_IRQ_DONE 0
`define ACH_IRQ_ERR 1
`endif

//--- tb/ach_checker_sva.sv
`timescale 1ns/1ps
module ach_checker (
	input wire core_clk, resetn, psel, penable, pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready, pslverr, historyErase, scaleErrClear
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire cw = psel && penable && pwrite && paddr == 12'h000;
	wire hw = cw && pwdata[11:0] == 12'h011;
	wire sw = cw && pwdata[11:0] == 12'h021;
	a_ready_high: assert property (pready)
		else $error("stall");
	a_no_slverr: assert property (!pslverr)
		else $error("slverr");
	a_erase_pulse: assert property (historyErase |=> !historyErase)
		else $error("long erase");
	a_scale_pulse: assert property (scaleErrClear |=> !scaleErrClear)
		else $error("long clear");
	a_one_action: assert property (!(historyErase && scaleErrClear))
		else $error("both");
	a_erase_cause: assert property (historyErase |-> $past(hw) || $past(hw, 2))
		else $error("stray erase");
	a_scale_cause: assert property (scaleErrClear |-> $past(sw) || $past(sw, 2))
		else $error("stray clear");
	a_other_quiet: assert property (cw && !hw && !sw |=> (!historyErase && !scaleErrClear)[*2])
		else $error("odd action");
endmodule // ach_checker
bind ach_alarm_command_handler ach_checker u_chk (.*);

//--- tb/ach_core_model.sv
`timescale 1ns/1ps
module ach_core_model (
	input wire core_clk,
	input wire historyErase,
	input wire scaleErrClear,
	input wire lowIn,
	output wire [7:0] faultMain,
	output wire [7:0] faultSub,
	output wire [15:0] cautionCode,
	output wire [2:0] faultAttr,
	output wire supplyLow,
	output reg [3:0] erases = 0,
	output reg [3:0] clears = 0
);
	// Fixed fault so every reply is predictable
	assign {faultMain, faultSub} = 16'h1234;
	assign cautionCode = 16'h5678;
	assign faultAttr = 3'b101;
	assign supplyLow = lowIn;
	always @(posedge core_clk) begin
		erases <= erases + historyErase;
		clears <= clears + scaleErrClear;
	end
endmodule // ach_core_model

//--- tb/test_alarm_command_handler.sv
`timescale 1ns/1ps
module test_alarm_command_handler;
	reg core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, lowIn = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rdat, rsp;
	integer failures = 0, total_checks = 0;
	wire pready, pslverr, historyErase, scaleErrClear, irq, supplyLow;
	wire [31:0] prdata;
	wire [7:0] faultMain, faultSub;
	wire [15:0] cautionCode;
	wire [2:0] faultAttr;
	wire [3:0] erases, clears;
	ach_alarm_command_handler u_dut (.*);
	ach_core_model u_core (.*);
	initial forever #50 core_clk = ~core_clk;
	task stop_test; begin
		if (failures == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	end endtask
	task chk(input [31:0] s, e); begin
		total_checks = total_checks + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	end endtask
	// Entered just after an edge; idle edge after so psel never toggles twice
	task xfer(input w, input [11:0] a, input [31:0] d); integer n; begin
		n = 0;
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk) penable <= 1;
		do @(posedge core_clk) n = n + 1; while (pready !== 1'b1 && n < 99);
		rdat = prdata;
		psel <= 0; penable <= 0;
		if (n >= 99) begin failures = failures + 1; stop_test; end
		@(posedge core_clk);
	end endtask
	task cmd(input [11:0] t, input [15:0] i, a, input [31:0] c, e); begin
		xfer(1, 12'h00C, c); xfer(1, 12'h004, {16'h0, i});
		xfer(1, 12'h008, {16'h0, a}); xfer(1, 12'h000, {20'h0, t});
		repeat (2) @(posedge core_clk);
		xfer(0, 12'h010, 0); rsp = rdat;
		xfer(0, 12'h014, 0); chk(rdat, e);
	end endtask
	task t_clear; begin
		cmd(12'h011, 0, 16'h00a5, 32'h0000_00a5, 0);
		chk(rsp, 32'h5678_3412);
		chk(erases, 1);
		cmd(12'h011, 0, 0, 32'h0002_0000, 0);
		chk(rsp, 32'h5678_0012);
	end endtask
	task t_errs; begin
		cmd(12'h011, 1, 0, 0, 32'h0032);
		cmd(12'h021, 2, 0, 32'h0100_0000, 32'h0032);
		cmd(12'h011, 0, 1, 0, 32'h0032);
		cmd(12'h021, 0, 0, 0, 32'h0043);
		cmd(12'h021, 0, 0, 32'h0300_0000, 32'h0043);
		cmd(12'h055, 0, 0, 0, 32'h0031);
		lowIn <= 1;
		cmd(12'h011, 0, 0, 0, 32'h0061);
		lowIn <= 0;
		cmd(12'h021, 0, 0, 32'h0100_0000, 0);
		chk(rsp, 32'h5678_3412);
		chk({erases, clears}, 8'h21);
	end endtask
	task t_attr; begin
		cmd(12'h002, 16'h3412, 0, 0, 0);
		chk(rsp, 32'h0000_00a0);
	end endtask
	task t_irq; begin
		xfer(1, 12'h01C, 3); xfer(1, 12'h020, 1);
		chk(irq, 0);
		cmd(12'h011, 0, 0, 0, 0);
		chk(irq, 1);
		xfer(1, 12'h01C, 1);
		chk(irq, 0);
		xfer(1, 12'h020, 2); cmd(12'h011, 0, 0, 0, 0);
		chk(irq, 0);
		xfer(0, 12'h01C, 0); chk(rdat, 1);
		xfer(0, 12'h0FC, 0); chk(rdat, 0);
		xfer(0, 12'h024, 0); chk(rdat, 32'h5678_3412);
	end endtask
	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		t_clear; t_errs; t_attr; t_irq;
		stop_test;
	end
endmodule // test_alarm_command_handler
